// [rtl/pdhrx_consts.svh]
// Timing, frame layout and filter constants for the 34 Mbit/s path receiver
`ifndef PDHRX_CONSTS_SVH
`define PDHRX_CONSTS_SVH

`define PDHRX_FAS_PATTERN 16'hF628
`define PDHRX_FAS_LAST_BIT 13'h000F
`define PDHRX_FRAME_LAST_BIT 13'h10C7
`define PDHRX_FAS_RESUME_BIT 13'h0010

`define PDHRX_EM_BYTE 10'h03D
`define PDHRX_TR_BYTE 10'h078
`define PDHRX_MA_BYTE 10'h0B3
`define PDHRX_NR_BYTE 10'h0EE
`define PDHRX_GC_BYTE 10'h129
`define PDHRX_EM_LAST_BIT 13'h01EF
`define PDHRX_MA_LAST_BIT 13'h059F

`define PDHRX_FAS_ERR_LIMIT 3'h4
`define PDHRX_FAS_OK_LIMIT 3'h5
`define PDHRX_BIP_BLOCK 10'h3E8
`define PDHRX_BIP_LIMIT 10'h3D9
`define PDHRX_RDI_FILTER 3'h5

`define PDHRX_AIS_X 3'h7
`define PDHRX_AIS_Y_LAST 13'h10C7
`define PDHRX_AIS_Z 4'h8

`endif

// [rtl/pdhrx_fifo.sv]
// The payload FIFO module lives beside the path receiver in pdhrx_path_term.sv

// [rtl/pdhrx_path_term.sv]
// Receive path termination for the 34 368 kbit/s framed signal
`include "pdhrx_consts.svh"

// Notes on behaviour
// - Four consecutive errored alignment words lose alignment.
// - Over 985 parity-errored frames per 1000 lose alignment.
// - Five consecutive good alignment words regain alignment.
// - Loss-of-frame defect tracks out-of-frame state exactly.
// - Loss of frame forces all-ones output promptly.
// - Monitoring state reports loss of frame.
// - Frame parity checked against next frame's parity byte.
// - Trace, operator, channel bytes and spare bits ignored.
// - Remote defect is first maintenance byte bit.
// - Remote defect filtered over five consecutive frames.
// - Monitoring state reports remote defect status.
// - Remote error bit is second maintenance bit.
// - One-way mode ignores remote bits, near-end only.
// - All-ones alarm by seven/4296/eight zero criteria.
// - All-ones alarm forces all-ones output promptly.
// - Monitoring state reports all-ones alarm.
// - Count parity-errored frames each second.
// - Flag seconds with loss of frame or alarm.
// - Count far-end errored blocks each second.
// - Flag seconds with remote defect present.
// - Monitoring state reports two counts and two flags each second.
// - Hunt for alignment pattern, then check each frame.
// - New hunt starts one bit past last alignment, or at next frame start after parity loss.
module pdhrx_path_term #(
  parameter int CNT_WIDTH = 14,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Line bit stream, one bit per accepted cycle, first bit of byte first
  input wire logic lineValid,
  input wire logic lineBit,
  output logic lineReady,
  // Recovered payload bytes
  output logic outValid,
  output logic [7:0] outData,
  input wire logic outReady,
  // Static configuration
  input wire logic monitorEnable,
  input wire logic oneWayMode,
  // One-second tick from the timebase
  input wire logic secTick,
  // Defect status
  output logic lofDefect,
  output logic lofReport,
  output logic aisReport,
  output logic rdiReport,
  // Per-second performance report
  output logic reportValid,
  output logic [CNT_WIDTH-1:0] nearErroredBlockCount,
  output logic nearDefectSecond,
  output logic [CNT_WIDTH-1:0] farErroredBlockCount,
  output logic farDefectSecond
);

  typedef struct packed {
    logic monitorMeta;
    logic monitorLevel;
    logic uniMeta;
    logic uniLevel;
    logic lineReady;
    pdhrx_pkg::pdhrx_align_t align;
    logic [15:0] shift;
    logic [12:0] bitCnt;
    logic [2:0] fasCnt;
    logic [7:0] bip;
    logic [7:0] prevBip;
    logic prevValid;
    logic [9:0] blkCnt;
    logic [9:0] blkErr;
    logic [2:0] rdiCnt;
    logic rdi;
    logic [12:0] aisWin;
    logic [2:0] aisZeros;
    logic [3:0] aisRun;
    logic ais;
    logic pushValid;
    logic [7:0] pushData;
    logic [CNT_WIDTH-1:0] nearEbc;
    logic nearDs;
    logic [CNT_WIDTH-1:0] farEbc;
    logic farDs;
    logic rptValid;
    logic [CNT_WIDTH-1:0] rptNearEbc;
    logic rptNearDs;
    logic [CNT_WIDTH-1:0] rptFarEbc;
    logic rptFarDs;
    logic lofRpt;
    logic aisRpt;
    logic rdiRpt;
  } pdhrx_state_t;

  pdhrx_state_t q;
  pdhrx_state_t d;
  logic fifoInReady;
  logic take;
  logic [15:0] shiftN;
  logic lof;
  logic frameErr;
  logic farErr;
  logic aisLow;

  function automatic logic isOverhead(input logic [9:0] idx);
    isOverhead = (idx == 10'h000) || (idx == 10'h001) ||
                 (idx == `PDHRX_EM_BYTE) || (idx == `PDHRX_TR_BYTE) ||
                 (idx == `PDHRX_MA_BYTE) || (idx == `PDHRX_NR_BYTE) ||
                 (idx == `PDHRX_GC_BYTE);
  endfunction

  function automatic logic [CNT_WIDTH-1:0] bump(input logic [CNT_WIDTH-1:0] v,
                                                input logic inc);
    bump = CNT_WIDTH'(v + {{(CNT_WIDTH - 1){1'b0}}, inc});
  endfunction

  always_comb begin
    d = q;
    frameErr = 1'b0;
    farErr = 1'b0;
    aisLow = 1'b0;
    shiftN = {q.shift[14:0], lineBit};
    lof = q.align != pdhrx_pkg::PDHRX_SYNC;
    // Settings are static but come from outside logic
    d.monitorMeta = monitorEnable;
    d.monitorLevel = q.monitorMeta;
    d.uniMeta = oneWayMode;
    d.uniLevel = q.uniMeta;
    // Ready lags the FIFO by a cycle; pushes are eight bits apart so it never overruns
    d.lineReady = fifoInReady;
    d.pushValid = 1'b0;
    take = lineValid && q.lineReady;

    if (take) begin
      d.shift = shiftN;
      d.bitCnt = (q.bitCnt == `PDHRX_FRAME_LAST_BIT) ? 13'h0000 : 13'(q.bitCnt + 13'h0001);
      d.bip[3'h7 - q.bitCnt[2:0]] = q.bip[3'h7 - q.bitCnt[2:0]] ^ lineBit;

      case (q.align)
        pdhrx_pkg::PDHRX_HUNT: begin
          // Sliding search moves on bit by bit from where the last lock was lost
          if (shiftN == `PDHRX_FAS_PATTERN) begin
            d.align = pdhrx_pkg::PDHRX_CONFIRM;
            d.fasCnt = 3'h1;
            d.bitCnt = `PDHRX_FAS_RESUME_BIT;
            d.bip = shiftN[15:8] ^ shiftN[7:0];
            d.prevValid = 1'b0;
          end
        end
        pdhrx_pkg::PDHRX_CONFIRM: begin
          if (q.bitCnt == `PDHRX_FAS_LAST_BIT) begin
            if (shiftN != `PDHRX_FAS_PATTERN) begin
              d.align = pdhrx_pkg::PDHRX_HUNT;
            end else if (3'(q.fasCnt + 3'h1) == `PDHRX_FAS_OK_LIMIT) begin
              d.align = pdhrx_pkg::PDHRX_SYNC;
              d.fasCnt = 3'h0;
              d.blkCnt = 10'h000;
              d.blkErr = 10'h000;
            end else begin
              d.fasCnt = 3'(q.fasCnt + 3'h1);
            end
          end
        end
        pdhrx_pkg::PDHRX_SYNC: begin
          if (q.bitCnt == `PDHRX_FAS_LAST_BIT) begin
            if (shiftN == `PDHRX_FAS_PATTERN) begin
              d.fasCnt = 3'h0;
            end else if (3'(q.fasCnt + 3'h1) == `PDHRX_FAS_ERR_LIMIT) begin
              d.align = pdhrx_pkg::PDHRX_HUNT;
              d.fasCnt = 3'h0;
            end else begin
              d.fasCnt = 3'(q.fasCnt + 3'h1);
            end
          end
          if (q.bitCnt == `PDHRX_EM_LAST_BIT && q.prevValid) begin
            frameErr = shiftN[7:0] != q.prevBip;
          end
          // Only the two top maintenance bits matter; the rest are dropped
          if (q.bitCnt == `PDHRX_MA_LAST_BIT && !q.uniLevel) begin
            farErr = shiftN[6];
            if (shiftN[7] != q.rdi) begin
              d.rdiCnt = 3'(q.rdiCnt + 3'h1);
              if (3'(q.rdiCnt + 3'h1) == `PDHRX_RDI_FILTER) begin
                d.rdi = shiftN[7];
                d.rdiCnt = 3'h0;
              end
            end else begin
              d.rdiCnt = 3'h0;
            end
          end
          if (frameErr) begin
            d.blkErr = 10'(q.blkErr + 10'h001);
          end
          if (q.bitCnt == `PDHRX_FRAME_LAST_BIT) begin
            d.blkCnt = 10'(q.blkCnt + 10'h001);
            if (10'(q.blkCnt + 10'h001) == `PDHRX_BIP_BLOCK) begin
              if (d.blkErr > `PDHRX_BIP_LIMIT) begin
                d.align = pdhrx_pkg::PDHRX_HUNT;
                d.fasCnt = 3'h0;
              end
              d.blkCnt = 10'h000;
              d.blkErr = 10'h000;
            end
          end
        end
        default: begin
          d.align = pdhrx_pkg::PDHRX_HUNT;
        end
      endcase

      if (q.align != pdhrx_pkg::PDHRX_HUNT && q.bitCnt == `PDHRX_FRAME_LAST_BIT) begin
        d.prevBip = d.bip;
        d.prevValid = 1'b1;
        d.bip = 8'h00;
      end

      // Zero-density alarm runs on raw bits, independent of framing
      d.aisWin = (q.aisWin == `PDHRX_AIS_Y_LAST) ? 13'h0000 : 13'(q.aisWin + 13'h0001);
      if (!lineBit && q.aisZeros != `PDHRX_AIS_X) begin
        d.aisZeros = 3'(q.aisZeros + 3'h1);
      end
      if (q.aisWin == `PDHRX_AIS_Y_LAST) begin
        aisLow = d.aisZeros < `PDHRX_AIS_X;
        d.aisZeros = 3'h0;
        if (aisLow != q.ais) begin
          d.aisRun = 4'(q.aisRun + 4'h1);
          if (4'(q.aisRun + 4'h1) == `PDHRX_AIS_Z) begin
            d.ais = aisLow;
            d.aisRun = 4'h0;
          end
        end else begin
          d.aisRun = 4'h0;
        end
      end

      // Overhead is stripped; during loss of frame or all-ones alarm every byte slot carries all-ones
      if (q.bitCnt[2:0] == 3'h7) begin
        if (lof || q.ais) begin
          d.pushValid = 1'b1;
          d.pushData = 8'hFF;
        end else if (!isOverhead(q.bitCnt[12:3])) begin
          d.pushValid = 1'b1;
          d.pushData = shiftN[7:0];
        end
      end
    end

    if (lof) begin
      d.prevValid = d.align == pdhrx_pkg::PDHRX_HUNT ? 1'b0 : d.prevValid;
    end
    if (q.uniLevel) begin
      d.rdi = 1'b0;
      d.rdiCnt = 3'h0;
    end
    if (q.align != pdhrx_pkg::PDHRX_SYNC && d.align == pdhrx_pkg::PDHRX_HUNT) begin
      d.rdiCnt = q.rdiCnt;
    end

    // Per-second filters; an event on the tick cycle lands in the closing second
    d.rptValid = 1'b0;
    if (secTick) begin
      d.rptValid = q.monitorLevel;
      // Held values move only with a report, so no silent change reaches the manager
      if (q.monitorLevel) begin
        d.rptNearEbc = bump(q.nearEbc, frameErr);
        d.rptNearDs = q.nearDs || lof || q.ais;
        d.rptFarEbc = bump(q.farEbc, farErr);
        d.rptFarDs = q.farDs || q.rdi;
      end
      d.nearEbc = {CNT_WIDTH{1'b0}};
      d.farEbc = {CNT_WIDTH{1'b0}};
      d.nearDs = 1'b0;
      d.farDs = 1'b0;
    end else begin
      d.nearEbc = bump(q.nearEbc, frameErr);
      d.nearDs = q.nearDs || lof || q.ais;
      d.farEbc = bump(q.farEbc, farErr);
      d.farDs = q.farDs || q.rdi;
    end

    d.lofRpt = q.monitorLevel && lof;
    d.aisRpt = q.monitorLevel && q.ais;
    d.rdiRpt = q.monitorLevel && q.rdi;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.align <= pdhrx_pkg::PDHRX_HUNT;
    end else begin
      q <= d;
    end
  end

  pdhrx_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) payloadFifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(q.pushValid),
    .inData(q.pushData),
    .inReady(fifoInReady),
    .outValid(outValid),
    .outData(outData),
    .outReady(outReady)
  );

  assign lineReady = q.lineReady;
  assign lofDefect = q.align != pdhrx_pkg::PDHRX_SYNC;
  assign lofReport = q.lofRpt;
  assign aisReport = q.aisRpt;
  assign rdiReport = q.rdiRpt;
  assign reportValid = q.rptValid;
  assign nearErroredBlockCount = q.rptNearEbc;
  assign nearDefectSecond = q.rptNearDs;
  assign farErroredBlockCount = q.rptFarEbc;
  assign farDefectSecond = q.rptFarDs;

endmodule

// Small synchronous FIFO with valid/ready on both sides
module pdhrx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Draining side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic notEmpty;
  } pdhrx_fifo_state_t;

  pdhrx_fifo_state_t q;
  pdhrx_fifo_state_t d;
  logic push;
  logic pop;

  assign inReady = q.count != (AW + 1)'(DEPTH);
  assign outValid = q.notEmpty;
  assign outData = q.mem[q.rdPtr];

  always_comb begin
    d = q;
    push = inValid && inReady;
    pop = outValid && outReady;
    if (push) begin
      d.mem[q.wrPtr] = inData;
      d.wrPtr = AW'(q.wrPtr + 1'b1);
    end
    if (pop) begin
      d.rdPtr = AW'(q.rdPtr + 1'b1);
    end
    if (push && !pop) begin
      d.count = (AW + 1)'(q.count + 1'b1);
    end else if (pop && !push) begin
      d.count = (AW + 1)'(q.count - 1'b1);
    end
    d.notEmpty = d.count != '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// [rtl/pdhrx_pkg.sv]
// Shared types of the 34 Mbit/s path receiver
package pdhrx_pkg;

  typedef enum logic [2:0] {
    PDHRX_HUNT    = 3'b001,
    PDHRX_CONFIRM = 3'b010,
    PDHRX_SYNC    = 3'b100
  } pdhrx_align_t;

endpackage

// [verif/pdhrx_far_end.sv]
// Far-end path termination model: framed line bits on demand
module pdhrx_far_end (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Line handshake
  input wire logic lineReady,
  output logic lineValid,
  output logic lineBit,
  // Scenario controls
  input wire logic rdiBit,
  input wire logic reiBit,
  input wire logic fasErr,
  input wire logic pace,
  output logic frameEnd
);
  logic [12:0] bitIdx;
  logic [7:0] bip;
  logic [7:0] em;
  logic [7:0] cur;
  logic gap;
  logic lastBit;
  logic [9:0] byteIdx;
  assign byteIdx = bitIdx[12:3];
  always_comb begin
    case (byteIdx)
      10'h000: cur = fasErr ? 8'hF7 : 8'hF6;
      10'h001: cur = 8'h28;
      10'h03D: cur = em;
      10'h0B3: cur = {rdiBit, reiBit, 6'h11};
      default: cur = byteIdx[7:0];
    endcase
  end
  // Between bits in slow pace the line shows the inverse, never the held bit
  assign lineValid = !gap;
  assign lineBit = gap ? !lastBit : cur[3'h7 - bitIdx[2:0]];
  assign frameEnd = lineValid && lineReady && (bitIdx == 13'h10C7);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitIdx <= 13'h0000;
      bip <= 8'h00;
      em <= 8'h00;
      gap <= 1'b0;
      lastBit <= 1'b0;
    end else if (lineValid && lineReady) begin
      gap <= pace;
      lastBit <= lineBit;
      bitIdx <= (bitIdx == 13'h10C7) ? 13'h0000 : bitIdx + 13'h0001;
      if (bitIdx[2:0] == 3'h7) bip <= bip ^ cur;
      if (bitIdx == 13'h10C7) begin
        em <= bip ^ cur;
        bip <= 8'h00;
      end
    end else begin
      gap <= 1'b0;
    end
  end
endmodule

// [verif/pdhrx_path_term_sva.sv]
// Port-level property checker for the 34 Mbit/s path receiver
module pdhrx_path_term_sva #(
  parameter int CNT_WIDTH = 14
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data path
  input wire logic outValid,
  input wire logic [7:0] outData,
  input wire logic outReady,
  // Configuration and tick
  input wire logic monitorEnable,
  input wire logic oneWayMode,
  input wire logic secTick,
  // Status and report
  input wire logic lofDefect,
  input wire logic lofReport,
  input wire logic rdiReport,
  input wire logic reportValid,
  input wire logic [CNT_WIDTH-1:0] nearErroredBlockCount,
  input wire logic nearDefectSecond,
  input wire logic farDefectSecond
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_lof_report_src: assert property (lofReport |-> $past(lofDefect))
    else $error("loss of frame reported without the defect");
  a_sync_holds: assert property ($fell(lofDefect) |=> !lofDefect [*8])
    else $error("alignment lost too soon after regain");
  a_hunt_holds: assert property ($rose(lofDefect) |=> lofDefect [*8])
    else $error("alignment regained too soon");
  a_oneway_rdi: assert property (oneWayMode [*6] |-> !rdiReport)
    else $error("remote defect reported in one-way mode");
  a_tick_report: assert property (monitorEnable [*4] ##0 secTick |=> reportValid)
    else $error("no report after tick");
  a_tick_quiet: assert property (!monitorEnable [*4] ##0 secTick |=> !reportValid)
    else $error("report while not monitoring");
  a_report_cause: assert property (reportValid |-> $past(secTick))
    else $error("report without tick");
  a_defect_sec: assert property (reportValid && $past(lofDefect, 2) |-> nearDefectSecond)
    else $error("defect second missed");
  a_counts_held: assert property (!reportValid |-> $stable(nearErroredBlockCount)
    && $stable(nearDefectSecond) && $stable(farDefectSecond))
    else $error("report values changed between reports");
  a_fifo_hold: assert property (outValid && !outReady |=> outValid && $stable(outData))
    else $error("output byte lost while stalled");
  c_regain: cover property ($fell(lofDefect));
  c_lose: cover property ($rose(lofDefect));
  c_report: cover property (reportValid && nearDefectSecond);
endmodule

// [verif/pdhrx_path_term_tb.sv]
// Self-checking bench for the 34 Mbit/s path receiver
module pdhrx_path_term_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic monitor, oneWay, rdi, rei, fasErr, pace;
    logic [3:0] frames;
    logic expLof, expRdi;
  } pdhrx_row_t;
  localparam pdhrx_row_t ROWS [5] = '{
    '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h6, 1'b0, 1'b0},
    '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h6, 1'b0, 1'b1},
    '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 1'b0, 1'b0},
    '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h1, 1'b0, 1'b0},
    '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h5, 1'b1, 1'b0}};
  logic clk, rst_n = 1'b0, outReady = 1'b1, monitorEnable = 1'b0, oneWayMode = 1'b0;
  logic secTick = 1'b0, rdiBit = 1'b0, reiBit = 1'b0, fasErr = 1'b0, pace = 1'b0;
  logic lineValid, lineBit, lineReady, outValid, frameEnd, lofDefect, lofReport;
  logic aisReport, rdiReport, reportValid, nearDefectSecond, farDefectSecond;
  logic [7:0] outData;
  logic [13:0] nearErroredBlockCount, farErroredBlockCount;
  int err_count = 0, checks_done = 0, cycles = 0;
  pdhrx_path_term dut_u (.clk(clk), .rst_n(rst_n), .lineValid(lineValid), .lineBit(lineBit),
    .lineReady(lineReady), .outValid(outValid), .outData(outData), .outReady(outReady),
    .monitorEnable(monitorEnable), .oneWayMode(oneWayMode), .secTick(secTick),
    .lofDefect(lofDefect), .lofReport(lofReport), .aisReport(aisReport),
    .rdiReport(rdiReport), .reportValid(reportValid),
    .nearErroredBlockCount(nearErroredBlockCount), .nearDefectSecond(nearDefectSecond),
    .farErroredBlockCount(farErroredBlockCount), .farDefectSecond(farDefectSecond));
  pdhrx_far_end far_u (.clk(clk), .rst_n(rst_n), .lineReady(lineReady),
    .lineValid(lineValid), .lineBit(lineBit), .rdiBit(rdiBit), .reiBit(reiBit),
    .fasErr(fasErr), .pace(pace), .frameEnd(frameEnd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic exp, input logic got);
    checks_done++;
    if (exp !== got) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic waitFrames(input logic [3:0] n);
    int seen;
    seen = 0;
    while (seen < n) begin
      @(posedge clk);
      if (frameEnd) seen++;
    end
  endtask
  // Ceiling sized for 18 full-rate frames plus one slow-paced frame and margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      err_count++;
      $display("MISMATCH timeout expected finish seen hang");
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      monitorEnable <= ROWS[i].monitor;
      oneWayMode <= ROWS[i].oneWay;
      rdiBit <= ROWS[i].rdi;
      reiBit <= ROWS[i].rei;
      fasErr <= ROWS[i].fasErr;
      pace <= ROWS[i].pace;
      waitFrames(ROWS[i].frames);
      #1;
      chk("lofDefect", ROWS[i].expLof, lofDefect);
      chk("lofReport", ROWS[i].expLof & ROWS[i].monitor, lofReport);
      chk("rdiReport", ROWS[i].expRdi, rdiReport);
      chk("aisReport", 1'b0, aisReport);
      $display("row %0d done", i);
      @(posedge clk);
    end
    outReady <= 1'b0;
    repeat (100) @(posedge clk);
    #1;
    chk("lineReadyFull", 1'b0, lineReady);
    chk("outDataOnes", 1'b1, outData == 8'hFF);
    @(posedge clk);
    outReady <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("lineReadyFree", 1'b1, lineReady);
    $display("stall test done");
    @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      secTick <= 1'b1;
      @(posedge clk);
      secTick <= 1'b0;
      #1;
      chk("reportValid", 1'b1, reportValid);
      chk("nearDefectSecond", 1'b1, nearDefectSecond);
      chk("farDefectSecond", k == 0, farDefectSecond);
      chk("farCountNonzero", k == 0, farErroredBlockCount != 14'h0000);
      chk("nearCountZero", 1'b1, nearErroredBlockCount == 14'h0000);
      @(posedge clk);
    end
    $display("report test done");
    monitorEnable <= 1'b0;
    repeat (4) @(posedge clk);
    secTick <= 1'b1;
    @(posedge clk);
    secTick <= 1'b0;
    #1;
    chk("quietReport", 1'b0, reportValid);
    chk("lofReportOff", 1'b0, lofReport);
    chk("lofDefectHeld", 1'b1, lofDefect);
    $display("quiet test done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("lofAtReset", 1'b1, lofDefect);
    chk("quietAtReset", 1'b0, outValid | reportValid);
    $display("reset test done");
    stop_test();
  end
endmodule
bind pdhrx_path_term pdhrx_path_term_sva #(.CNT_WIDTH(CNT_WIDTH)) sva_u (.clk(clk),
  .rst_n(rst_n), .outValid(outValid), .outData(outData), .outReady(outReady),
  .monitorEnable(monitorEnable), .oneWayMode(oneWayMode), .secTick(secTick),
  .lofDefect(lofDefect), .lofReport(lofReport), .rdiReport(rdiReport),
  .reportValid(reportValid), .nearErroredBlockCount(nearErroredBlockCount),
  .nearDefectSecond(nearDefectSecond), .farDefectSecond(farDefectSecond));
